// ---- asq_pkg.sv ----
// shared constants and bus carrier types of the conversion-mode sequencer
package asq_pkg;

   // register byte addresses on the bus
   localparam logic [7:0] ADR_MODE = 8'h00;   // mode_select_reg
   localparam logic [7:0] ADR_CHEN = 8'h04;   // channel_enable_reg
   localparam logic [7:0] ADR_START = 8'h08;  // start_address_reg
   localparam logic [7:0] ADR_STATUS = 8'h0c; // status_reg
   localparam logic [7:0] ADR_RESULT = 8'h10; // result of channel at pointer

   // mode_select_reg fields
   localparam int MODE_LO = 0;
   localparam int MODE_HI = 1;
   localparam int BIT_IRQ_EN = 2;             // irq_enable
   localparam int BIT_EXT_CLK = 3;            // external_clock_select
   localparam logic [7:0] MODE_RESET = 8'h00;

   // operating modes
   localparam logic [1:0] MODE_IDLE = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_SCAN = 2'h2;
   localparam logic [1:0] MODE_CONT = 2'h3;

   // start_address_reg fields
   localparam int BIT_CONV_EN = 7;            // convert_enable
   localparam int BIT_PTR_LOAD = 4;           // pointer_load_enable
   localparam int CH_HI = 3;                  // channel_addr_bits
   localparam int CH_LO = 1;

   // status_reg fields
   localparam int ST_IRQ = 7;
   localparam int ST_ALL_DONE = 6;
   localparam int ST_ACTIVE = 5;

   // result register fields
   localparam int RES_VALID = 15;
   localparam int RES_W = 10;

   // reset values and timing
   localparam logic [7:0] CHEN_RESET = 8'h00;
   localparam logic [7:0] START_RESET = 8'h00;
   localparam int CONV_TICKS = 14;            // converter clock ticks per channel
   localparam int OSC_DIV = 4;                // mclk cycles per internal tick

   // wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } asq_wb_req_t;

   // wishbone answer to the master
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } asq_wb_rsp_t;

endpackage

// ---- asq_result_mem.sv ----
// per-channel result storage with registered read data
`timescale 1ns/10ps
module asq_result_mem #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   // clock
   input wire logic mclk,
   // write side
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // read side
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] mem [DEPTH];   // no reset: contents undefined until converted

   // write port
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read, one cycle behind the address
   always_ff @(posedge mclk) begin
      rdData <= mem[rdAddr];
   end

endmodule

// ---- asq_sequencer.sv ----
// conversion-mode sequencer with wishbone register slave
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module asq_sequencer
   import asq_pkg::*;
#(
   parameter int CONV_TICKS_P = CONV_TICKS,
   parameter int OSC_DIV_P = OSC_DIV
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // register bus
   input wire asq_pkg::asq_wb_req_t wbReq,
   output asq_pkg::asq_wb_rsp_t wbRsp,
   // analog side
   input wire logic extClk,
   input wire logic [asq_pkg::RES_W-1:0] adcResult,
   output logic [2:0] convChannel,
   output logic convClkEn,
   output logic oscRun,
   output logic oscShutdown,
   // open-drain interrupt pin
   output logic irqOut,
   output logic irqOe
);
   import asq_pkg::*;

   typedef enum {S_IDLE, S_CONV, S_GAP} asq_state_t;

   asq_state_t state_q;               // conversion engine state
   logic [7:0] modeSel_q;             // mode_select_reg
   logic [7:0] chanEn_q;              // channel_enable_reg
   logic [7:0] startReg_q;            // start_address_reg as written
   logic [2:0] ptr_q;                 // channel_pointer
   logic [7:0] valid_q;               // result_valid per channel
   logic irqFlag_q;                   // status interrupt flag
   logic allDone_q;                   // all_done
   logic convEn_q;                    // convert_enable held for scans
   logic [4:0] tickCnt_q;             // ticks into current conversion
   logic [3:0] divCnt_q;              // internal oscillator divider
   logic pend_q;                      // request seen, answer next cycle
   logic ack_q;
   logic [31:0] rdat_q;
   logic [2:0] extSync_q;             // [0],[1] synchroniser, [2] edge history
   logic [RES_W-1:0] memRd;

   // field views
   logic [1:0] mode;
   logic irqEn;
   logic extSel;
   assign mode = modeSel_q[MODE_HI:MODE_LO];
   assign irqEn = modeSel_q[BIT_IRQ_EN];
   assign extSel = modeSel_q[BIT_EXT_CLK];

   // bus access decode, acted on at the edge that raises ack
   logic acc, wr, rd;
   logic modeWr, chenWr, startWr, statRd, resRd;
   logic [7:0] wdat;
   assign acc = pend_q & ~ack_q;
   assign wr = acc & wbReq.we & wbReq.sel[0];
   assign rd = acc & ~wbReq.we;
   assign wdat = wbReq.dat[7:0];
   assign modeWr = wr & (wbReq.adr == ADR_MODE);
   assign chenWr = wr & (wbReq.adr == ADR_CHEN);
   assign startWr = wr & (wbReq.adr == ADR_START);
   assign statRd = rd & (wbReq.adr == ADR_STATUS);
   assign resRd = rd & (wbReq.adr == ADR_RESULT);

   // first enabled channel above 'from', wrapping; 'from' itself last
   function automatic logic [2:0] nextEn(input logic [2:0] from, input logic [7:0] en);
      logic [2:0] idx;
      logic found;
      nextEn = from;
      found = 1'b0;
      for (int i = 1; i <= 8; i++) begin
         idx = from + 3'(i);
         if (!found && en[idx]) begin
            nextEn = idx;
            found = 1'b1;
         end
      end
   endfunction

   // engine events
   logic abort, startConv, tick, convDone, allValidAfter, scanEnd;
   logic [7:0] ptrHot;
   assign abort = modeWr | chenWr | (startWr & (wdat[BIT_CONV_EN] | wdat[BIT_PTR_LOAD])) | resRd;
   // a conversion on command, or in single mode the next channel after a result read
   assign startConv = (startWr & wdat[BIT_CONV_EN] & (mode != MODE_IDLE))
      | (resRd & (mode == MODE_SINGLE));
   assign tick = extSel ? (extSync_q[1] & ~extSync_q[2]) : (divCnt_q == 4'(OSC_DIV_P - 1));
   assign convDone = (state_q == S_CONV) & tick & (tickCnt_q == 5'(CONV_TICKS_P - 1));
   assign ptrHot = 8'h01 << ptr_q;
   assign allValidAfter = ((valid_q | ptrHot) & chanEn_q) == chanEn_q;
   // single scan ends once all enabled results are valid, or on a stop
   assign scanEnd = allValidAfter | ~convEn_q;

   // external converter clock: two flops, then edge history
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         extSync_q <= 3'h0;
      end else begin
         extSync_q <= {extSync_q[1], extSync_q[0], extClk};
      end
   end

   // internal oscillator divider, counts only while it runs
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         divCnt_q <= 4'h0;
      end else if (state_q == S_IDLE || extSel || divCnt_q == 4'(OSC_DIV_P - 1)) begin
         divCnt_q <= 4'h0;
      end else begin
         divCnt_q <= divCnt_q + 4'h1;
      end
   end

   // wishbone handshake: ack two cycles after the request appears
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pend_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         pend_q <= wbReq.cyc & wbReq.stb & ~ack_q & ~pend_q;
         ack_q <= acc;
      end
   end

   // read data mux; unmapped addresses answer zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdat_q <= 32'h0;
      end else if (rd) begin
         case (wbReq.adr)
            ADR_MODE: rdat_q <= {24'h0, modeSel_q};
            ADR_CHEN: rdat_q <= {24'h0, chanEn_q};
            ADR_START: rdat_q <= {24'h0, startReg_q};
            ADR_STATUS: rdat_q <= {24'h0, irqFlag_q, allDone_q, state_q == S_CONV, 1'b0, ptr_q, 1'b0};
            ADR_RESULT: rdat_q <= {16'h0, valid_q[ptr_q], 5'h0, memRd};
            default: rdat_q <= 32'h0;
         endcase
      end
   end

   // configuration registers; mode zero clears everything
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         modeSel_q <= MODE_RESET;
         chanEn_q <= CHEN_RESET;
         startReg_q <= START_RESET;
      end else if (modeWr && wdat == MODE_RESET) begin
         modeSel_q <= MODE_RESET;
         chanEn_q <= CHEN_RESET;
         startReg_q <= START_RESET;
      end else begin
         if (modeWr) begin
            modeSel_q <= wdat;
         end
         if (chenWr) begin
            chanEn_q <= wdat;
         end
         if (startWr) begin
            startReg_q <= wdat;
         end
      end
   end

   // convert_enable: kept for scans, a zero write stops after this channel
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         convEn_q <= 1'b0;
      end else if (modeWr && wdat == MODE_RESET) begin
         convEn_q <= 1'b0;
      end else if (startWr) begin
         convEn_q <= wdat[BIT_CONV_EN];
      end
   end

   // conversion engine
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= S_IDLE;
         tickCnt_q <= 5'h0;
      end else if (mode == MODE_IDLE || (modeWr && wdat == MODE_RESET)) begin
         state_q <= S_IDLE;
         tickCnt_q <= 5'h0;
      end else if (startConv) begin
         state_q <= S_CONV;
         tickCnt_q <= 5'h0;
      end else if (abort) begin
         state_q <= S_IDLE;
         tickCnt_q <= 5'h0;
      end else begin
         case (state_q)
            S_CONV: begin
               if (convDone) begin
                  tickCnt_q <= 5'h0;
                  // scans go through a gap so the active flag drops
                  if (mode == MODE_SINGLE) begin
                     state_q <= S_IDLE;
                  end else if (mode == MODE_SCAN && scanEnd) begin
                     state_q <= S_IDLE;
                  end else if (mode == MODE_CONT && !convEn_q) begin
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_GAP;
                  end
               end else if (tick) begin
                  tickCnt_q <= tickCnt_q + 5'h1;
               end
            end
            S_GAP: begin
               state_q <= S_CONV;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // channel pointer
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ptr_q <= 3'h0;
      end else if (modeWr && wdat == MODE_RESET) begin
         ptr_q <= 3'h0;
      end else if (startWr && wdat[BIT_PTR_LOAD]) begin
         ptr_q <= wdat[CH_HI:CH_LO];
      end else if (resRd) begin
         ptr_q <= nextEn(ptr_q, chanEn_q);
      end else if (convDone && mode != MODE_SINGLE) begin
         ptr_q <= nextEn(ptr_q, chanEn_q);
      end
      // a single conversion leaves the pointer where it was
   end

   // per-channel valid flags; completion wins over a clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         valid_q <= 8'h0;
      end else begin
         if (modeWr || chenWr) begin
            valid_q <= 8'h0;             // start writes leave them
         end else if (resRd) begin
            valid_q <= valid_q & ~ptrHot;
         end
         if (convDone) begin
            valid_q[ptr_q] <= 1'b1;
         end
      end
   end

   // interrupt and all-done flags; a set beats a clear in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irqFlag_q <= 1'b0;
         allDone_q <= 1'b0;
      end else begin
         if (statRd || resRd || modeWr || chenWr) begin
            irqFlag_q <= 1'b0;
         end
         if (resRd || modeWr || chenWr) begin
            allDone_q <= 1'b0;
         end
         if (convDone && (mode == MODE_SINGLE || (mode == MODE_SCAN && scanEnd))) begin
            irqFlag_q <= 1'b1;
         end
         if (convDone && allValidAfter && chanEn_q != 8'h0) begin
            allDone_q <= 1'b1;
         end
      end
   end

   // pin-facing outputs, all from flops
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irqOe <= 1'b0;
         irqOut <= 1'b0;
         oscRun <= 1'b0;
         oscShutdown <= 1'b0;
         convClkEn <= 1'b0;
         convChannel <= 3'h0;
      end else begin
         // continuous scan never pulls the pin
         irqOe <= irqFlag_q & irqEn & (mode == MODE_SINGLE || mode == MODE_SCAN);
         irqOut <= 1'b0;                 // open drain only ever pulls low
         oscRun <= (state_q != S_IDLE) & ~extSel;
         oscShutdown <= (mode == MODE_IDLE) & extSel;
         convClkEn <= (state_q != S_IDLE);
         convChannel <= ptr_q;
      end
   end

   assign wbRsp.ack = ack_q;
   assign wbRsp.dat = rdat_q;

   // result storage, read at the pointer
   asq_result_mem #(
      .WIDTH(RES_W),
      .DEPTH(8),
      .AW(3)
   ) u_mem (
      .mclk(mclk),
      .wrEn(convDone),
      .wrAddr(ptr_q),
      .wrData(adcResult),
      .rdAddr(ptr_q),
      .rdData(memRd)
   );

   // checks on the sequencing
   sequence sGapThenConv;
      state_q == S_GAP ##1 state_q == S_CONV;
   endsequence

   a_idle_inhibit: assert property (@(posedge mclk) disable iff (!resetn)
      mode == MODE_IDLE |-> ##2 !convClkEn && !oscRun) else $error("clocking not inhibited in idle");
   a_idle_release: assert property (@(posedge mclk) disable iff (!resetn)
      mode == MODE_IDLE |=> !irqOe && state_q == S_IDLE) else $error("idle kept pin or engine");
   a_zero_reset: assert property (@(posedge mclk) disable iff (!resetn)
      modeWr && wdat == MODE_RESET |=> modeSel_q == 8'h0 && chanEn_q == 8'h0 && ptr_q == 3'h0)
      else $error("mode zero write did not reset");
   a_single_start: assert property (@(posedge mclk) disable iff (!resetn)
      startWr && wdat[BIT_CONV_EN] && mode == MODE_SINGLE && !modeWr |=> state_q == S_CONV)
      else $error("single conversion not started");
   a_single_done: assert property (@(posedge mclk) disable iff (!resetn)
      convDone && mode == MODE_SINGLE && !abort |=> irqFlag_q && state_q == S_IDLE && ptr_q == $past(ptr_q))
      else $error("single completion wrong");
   a_ptr_load: assert property (@(posedge mclk) disable iff (!resetn)
      startWr && wdat[BIT_PTR_LOAD] |=> ptr_q == $past(wdat[CH_HI:CH_LO]))
      else $error("pointer not loaded");
   a_scan_gap: assert property (@(posedge mclk) disable iff (!resetn)
      convDone && mode == MODE_SCAN && !scanEnd && !abort |=> sGapThenConv)
      else $error("scan gap missing");
   a_cont_noirq: assert property (@(posedge mclk) disable iff (!resetn)
      mode == MODE_CONT [*2] |-> !irqOe) else $error("interrupt pin in continuous scan");
   a_abort_stops: assert property (@(posedge mclk) disable iff (!resetn)
      abort && !startConv |=> state_q == S_IDLE) else $error("abort ignored");
   a_valid_keep: assert property (@(posedge mclk) disable iff (!resetn)
      startWr && !convDone |=> valid_q == $past(valid_q)) else $error("start write touched valid");
   a_stop_after: assert property (@(posedge mclk) disable iff (!resetn)
      convDone && mode == MODE_CONT && !convEn_q && !startConv |=> state_q == S_IDLE ##1 state_q == S_IDLE)
      else $error("scan kept running after stop");

endmodule

// ---- asq_conv_model.sv ----
// converter-side model: external converter clock and channel samples
`timescale 1ns/10ps
module asq_conv_model
   import asq_pkg::*;
(
   // control from the block
   input wire logic convClkEn,
   input wire logic [2:0] convChannel,
   // converter answers
   output logic extClk,
   output logic [asq_pkg::RES_W-1:0] adcResult
);
   // clock runs only while clocking is allowed, rests low otherwise
   initial begin
      extClk = 1'b0;
      forever begin
         #80;
         extClk = convClkEn ? ~extClk : 1'b0;
      end
   end
   // value carries the channel so a wrong mux select shows up
   assign adcResult = {7'h55, convChannel};
endmodule

// ---- tb_asq_sequencer.sv ----
// self-checking bench of the conversion-mode sequencer
`timescale 1ns/10ps
module tb_asq_sequencer;
   import asq_pkg::*;
   // clock, reset, bus
   logic mclk;
   logic resetn;
   asq_wb_req_t wbReq;
   asq_wb_rsp_t wbRsp;
   // converter side and pin
   logic extClk;
   logic [RES_W-1:0] adcResult;
   logic [2:0] convChannel;
   logic convClkEn, oscRun, oscShutdown, irqOut, irqOe;
   // score and last read word
   int fails, checks_done;
   logic [31:0] rd;

   // short counts keep each conversion a few dozen cycles
   asq_sequencer #(.CONV_TICKS_P(4), .OSC_DIV_P(4)) i_asq_sequencer (.mclk(mclk), .resetn(resetn),
      .wbReq(wbReq), .wbRsp(wbRsp), .extClk(extClk), .adcResult(adcResult), .convChannel(convChannel),
      .convClkEn(convClkEn), .oscRun(oscRun), .oscShutdown(oscShutdown), .irqOut(irqOut), .irqOe(irqOe));
   asq_conv_model i_asq_conv_model (.convClkEn(convClkEn), .convChannel(convChannel), .extClk(extClk),
      .adcResult(adcResult));

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // verdict, the single exit point
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // compare a bus word
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // compare a single pin or bit
   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask

   // expected result word: valid at bit 15, channel-tagged sample below
   function automatic logic [31:0] expv(input logic [2:0] ch);
      return {16'h0, 1'b1, 5'h0, 7'h55, ch};
   endfunction

   // one classic cycle; held until ack is sampled, then released
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
      do begin
         @(posedge mclk);
         n++;
      end while (wbRsp.ack !== 1'b1 && n < 20);
      rd = wbRsp.dat;
      wbReq <= '0;
      if (wbRsp.ack !== 1'b1) begin
         fails++;
         $display("FAIL %0t no bus ack", $time);
         tally_and_finish();
      end
   endtask

   // bounded wait for the interrupt pin
   task automatic wait_irq(input logic val, input int lim);
      int n;
      n = 0;
      while (irqOe !== val && n < lim) begin
         @(posedge mclk);
         n++;
      end
      if (irqOe !== val) begin
         fails++;
         $display("FAIL %0t interrupt pin wait ran out", $time);
         tally_and_finish();
      end
   endtask

   // state just after reset, unmapped place
   task automatic t_reset;
      chk_bit(irqOe, 1'b0, "pin released");
      chk_bit(convClkEn, 1'b0, "clocking off");
      wb_xfer(1'b0, ADR_MODE, 8'h00);
      chk_word(rd, 32'h0, "mode reset");
      wb_xfer(1'b1, 8'h40, 8'hff);
      wb_xfer(1'b0, 8'h40, 8'h00);
      chk_word(rd, 32'h0, "unmapped read");
   endtask

   // single conversion on a disabled channel, then read-convert chain
   task automatic t_single;
      wb_xfer(1'b1, ADR_CHEN, 8'h06);
      wb_xfer(1'b1, ADR_MODE, 8'h05);
      wb_xfer(1'b1, ADR_START, 8'h1a);
      wb_xfer(1'b0, ADR_STATUS, 8'h00);
      chk_word({24'h0, rd[7:0]}, 32'h0a, "pointer load");
      chk_bit(convClkEn, 1'b0, "load does not convert");
      wb_xfer(1'b0, ADR_START, 8'h00);
      chk_word(rd, 32'h1a, "start register reads back");
      wb_xfer(1'b1, ADR_START, 8'h80);
      // the oscillator flop follows the engine state one edge late
      @(posedge mclk);
      chk_bit(oscRun, 1'b1, "oscillator on");
      wb_xfer(1'b0, ADR_STATUS, 8'h00);
      chk_word({24'h0, rd[7:0]}, 32'h2a, "active at start");
      wait_irq(1'b1, 200);
      chk_bit(irqOut, 1'b0, "enabled pin pulls low");
      chk_bit(oscRun, 1'b0, "oscillator stopped");
      wb_xfer(1'b0, ADR_RESULT, 8'h00);
      chk_word(rd, expv(3'd5), "result of started channel");
      repeat (3) @(posedge mclk);
      chk_bit(irqOe, 1'b0, "read releases pin");
      chk_word({29'h0, convChannel}, 32'h1, "next enabled channel");
      wait_irq(1'b1, 200);
      wb_xfer(1'b0, ADR_STATUS, 8'h00);
      chk_word({24'h0, rd[7:0]}, 32'h82, "flag, pointer, not all done");
      repeat (3) @(posedge mclk);
      chk_bit(irqOe, 1'b0, "status read clears flag");
   endtask

   // single scan from channel 2 over channels 0, 2, 7
   task automatic t_scan;
      logic [2:0] order [3];
      order = '{3'd2, 3'd7, 3'd0};
      wb_xfer(1'b1, ADR_MODE, 8'h06);
      wb_xfer(1'b1, ADR_CHEN, 8'h85);
      wb_xfer(1'b1, ADR_START, 8'h14);
      wb_xfer(1'b1, ADR_START, 8'h80);
      wait_irq(1'b1, 400);
      chk_bit(oscRun, 1'b0, "oscillator off after scan");
      wb_xfer(1'b0, ADR_STATUS, 8'h00);
      chk_word({24'h0, rd[7:0]}, 32'hc4, "scan end status");
      for (int i = 0; i < 3; i++) begin
         wb_xfer(1'b0, ADR_RESULT, 8'h00);
         chk_word(rd, expv(order[i]), "scan result order");
      end
   endtask

   // channel enable write in mid-scan aborts it
   task automatic t_abort;
      wb_xfer(1'b1, ADR_START, 8'h80);
      wb_xfer(1'b1, ADR_CHEN, 8'h85);
      repeat (150) @(posedge mclk);
      chk_bit(irqOe, 1'b0, "aborted scan raises nothing");
      wb_xfer(1'b0, ADR_STATUS, 8'h00);
      chk_word({24'h0, rd[7:5], 5'h0}, 32'h0, "aborted scan flags");
   endtask

   // continuous scan on the external clock, then early stop
   task automatic t_cont;
      int n;
      n = 0;
      wb_xfer(1'b1, ADR_MODE, 8'h0f);
      wb_xfer(1'b1, ADR_CHEN, 8'h03);
      wb_xfer(1'b1, ADR_START, 8'h90);
      do begin
         wb_xfer(1'b0, ADR_STATUS, 8'h00);
         chk_bit(irqOe, 1'b0, "no pin in continuous scan");
         n++;
      end while (rd[ST_ALL_DONE] !== 1'b1 && n < 80);
      chk_bit(rd[ST_ALL_DONE], 1'b1, "all done set");
      // a poll that ran out has been counted; stop here
      if (rd[ST_ALL_DONE] !== 1'b1) begin
         tally_and_finish();
      end
      chk_bit(rd[ST_IRQ], 1'b0, "flag held off");
      wb_xfer(1'b1, ADR_START, 8'h00);
      // stop only takes hold after the running channel, so allow one conversion
      repeat (100) @(posedge mclk);
      chk_bit(convClkEn, 1'b0, "stopped after channel");
      wb_xfer(1'b1, ADR_START, 8'h10);
      wb_xfer(1'b0, ADR_RESULT, 8'h00);
      chk_word(rd, expv(3'd0), "continuous result");
   endtask

   // idle entry releases the pin; zero mode write acts as reset
   task automatic t_idle;
      wb_xfer(1'b1, ADR_MODE, 8'h05);
      wb_xfer(1'b1, ADR_START, 8'h80);
      wait_irq(1'b1, 200);
      wb_xfer(1'b1, ADR_MODE, 8'h08);
      repeat (2) @(posedge mclk);
      chk_bit(irqOe, 1'b0, "idle releases pin");
      chk_bit(convClkEn, 1'b0, "idle inhibits clocking");
      chk_bit(oscShutdown, 1'b1, "external select shuts oscillator");
      wb_xfer(1'b1, ADR_CHEN, 8'h3c);
      wb_xfer(1'b1, ADR_MODE, 8'h00);
      repeat (2) @(posedge mclk);
      chk_bit(oscShutdown, 1'b0, "no shutdown on internal");
      wb_xfer(1'b0, ADR_CHEN, 8'h00);
      chk_word(rd, 32'h0, "zero mode clears enables");
   endtask

   // main sequence
   initial begin
      fails = 0;
      checks_done = 0;
      resetn = 1'b0;
      wbReq = '0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_single();
      t_scan();
      t_abort();
      t_cont();
      t_idle();
      tally_and_finish();
   end

   // watchdog against a hang outside the bounded waits
   initial begin
      #1ms;
      fails++;
      $display("FAIL %0t run too long", $time);
      tally_and_finish();
   end
endmodule
